// *** wdc_pkg.sv ***
// package: watchdog control unit constants and register map
package wdc_pkg;
  localparam logic [7:0]  WDC_ADDR_RESTART_KEY = 8'ha6;
  localparam logic [7:0]  WDC_ADDR_CONTROL     = 8'ha7;
  localparam logic [7:0]  WDC_CONTROL_RESET    = 8'h00;
  localparam logic [7:0]  WDC_KEY_FIRST        = 8'h1e;
  localparam logic [7:0]  WDC_KEY_SECOND       = 8'he1;
  // field positions in watchdog_control
  localparam int          WDC_BIT_PRESCALE_LO  = 5;
  localparam int          WDC_BIT_IDLE_FREEZE  = 4;
  localparam int          WDC_BIT_RST_OUT_DIS  = 3;
  localparam int          WDC_BIT_HW_MODE      = 2;
  localparam int          WDC_BIT_SW_RESTART   = 1;
  localparam int          WDC_BIT_SW_ENABLE    = 0;
  // shortest period is 16K machine cycles, i.e. 2**14
  localparam int          WDC_BASE_LOG2        = 14;
  localparam int          WDC_CNT_W            = 21;
  // internal and pin reset pulse length in machine cycles
  localparam int          WDC_RESET_PULSE      = 16;
  localparam logic [4:0]  WDC_PULSE_W_ONE      = 5'h01;

  typedef enum logic [1:0] {
    WDC_KEY_IDLE  = 2'b00,
    WDC_KEY_GOT1  = 2'b01
  } wdc_key_type;
endpackage

// *** wdc_sync.sv ***
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module wdc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,   // clock
  input  wire logic         i_rst,   // async reset, high
  input  wire logic [W-1:0] i_d,     // async level
  output logic      [W-1:0] o_q      // synchronised level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } wdc_sync_type;

  wdc_sync_type st_reg;
  wdc_sync_type st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = i_d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_q = st_reg.s2;
endmodule

// *** wdc_watchdog.sv ***
// watchdog control unit: control and restart-key registers, counter, reset out
`timescale 1ns/1ps
module wdc_watchdog
  import wdc_pkg::*;
#(
  parameter int PULSE_LEN = WDC_RESET_PULSE
) (
  input  wire logic       I_MCLK,         // machine-cycle clock, 25 MHz
  input  wire logic       I_SYS_RST,      // power-on / warm reset, async high
  input  wire logic [7:0] I_ADDR,         // register address
  input  wire logic [7:0] I_WDATA,        // write data
  input  wire logic       I_WR,           // write strobe
  input  wire logic       I_RD,           // read strobe
  output logic      [7:0] O_RDATA,        // read data, cycle after strobe
  input  wire logic       I_IDLE,         // device in idle mode, async level
  input  wire logic       I_POWER_DOWN,   // device in power-down, async level
  output logic            O_CORE_RST,     // internal core reset pulse
  output logic            O_RST_PIN_O,    // reset pin drive value
  output logic            O_RST_PIN_OE,   // reset pin output enable
  output logic            O_RUNNING       // watchdog counting enabled
);
  import wdc_pkg::*;

  typedef struct packed {
    logic [2:0]           prescale;
    logic                 idle_freeze;
    logic                 reset_output_disable;
    logic                 hardware_mode;
    logic                 software_restart;
    logic                 software_enable;
    logic                 hw_started;
    wdc_key_type          key_state;
    logic [WDC_CNT_W-1:0] count;
    logic [4:0]           pulse_cnt;
    logic                 pulse_pin;
    logic [7:0]           rdata;
  } wdc_state_type;

  wdc_state_type st_reg;
  wdc_state_type st_next;

  logic            idle_s;
  logic            pd_s;
  logic [1:0]      sync_q;
  logic            running;
  logic            advance;
  logic            timeout;
  logic            wr_ctl;
  logic            wr_key;
  logic            key_done;
  logic [7:0]      ctl_view;
  logic [WDC_CNT_W-1:0] limit;

  ////////////////////////////////////////////////////////////////////////////
  // synchronise idle and power-down status
  wdc_sync #(
    .W (2)
  ) u_sync (
    .i_clk (I_MCLK),
    .i_rst (I_SYS_RST),
    .i_d   ({I_POWER_DOWN, I_IDLE}),
    .o_q   (sync_q)
  );
  assign idle_s = sync_q[0];
  assign pd_s   = sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // decode and derived conditions
  assign wr_ctl = I_WR && (I_ADDR == WDC_ADDR_CONTROL);
  assign wr_key = I_WR && (I_ADDR == WDC_ADDR_RESTART_KEY);
  // second key byte accepted only right after the first
  assign key_done = wr_key && (I_WDATA == WDC_KEY_SECOND)
                    && (st_reg.key_state == WDC_KEY_GOT1);

  // running is the mode-selected enable
  assign running = st_reg.hardware_mode ? st_reg.hw_started : st_reg.software_enable;

  // power-down stops counting; idle only if idle_freeze set
  assign advance = running && !pd_s && !(idle_s && st_reg.idle_freeze);

  // period is 2**(14+code) machine cycles
  assign limit   = WDC_CNT_W'((64'd1 << (WDC_BASE_LOG2 + int'(st_reg.prescale))) - 64'd1);
  // a prescale cut below the present count still ends the period at once
  assign timeout = advance && (st_reg.count >= limit);

  // enable reads back running status in hardware mode
  always_comb begin
    ctl_view = {st_reg.prescale, st_reg.idle_freeze, st_reg.reset_output_disable,
                st_reg.hardware_mode, st_reg.software_restart, 1'b0};
    ctl_view[WDC_BIT_SW_ENABLE] = st_reg.hardware_mode ? st_reg.hw_started
                                                       : st_reg.software_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = 8'h00;

    if (I_RD) begin
      if (I_ADDR == WDC_ADDR_CONTROL) begin
        st_next.rdata = ctl_view;
      end else begin
        st_next.rdata = 8'h00;
      end
    end

    // self-clear of software_restart one machine cycle after it is set, in software mode only; it stays set in hardware mode
    if (st_reg.software_restart && !st_reg.hardware_mode) begin
      st_next.software_restart = 1'b0;
    end

    // counter
    if (advance) begin
      st_next.count = timeout ? '0 : st_reg.count + 1'b1;
    end
    if (st_reg.software_restart && !st_reg.hardware_mode) begin
      st_next.count = '0;
    end

    // control register write
    if (wr_ctl) begin
      st_next.prescale             = I_WDATA[WDC_BIT_PRESCALE_LO +: 3];
      st_next.idle_freeze          = I_WDATA[WDC_BIT_IDLE_FREEZE];
      st_next.reset_output_disable = I_WDATA[WDC_BIT_RST_OUT_DIS];
      st_next.software_restart     = I_WDATA[WDC_BIT_SW_RESTART];
      // mode cannot leave hardware mode once started
      if (!st_reg.hw_started) begin
        st_next.hardware_mode = I_WDATA[WDC_BIT_HW_MODE];
      end
      // enable bit write-ignored in hardware mode
      if (!st_reg.hardware_mode) begin
        st_next.software_enable = I_WDATA[WDC_BIT_SW_ENABLE];
      end
    end

    // key sequence tracker
    if (wr_key) begin
      if (I_WDATA == WDC_KEY_FIRST) begin
        st_next.key_state = WDC_KEY_GOT1;
      end else begin
        st_next.key_state = WDC_KEY_IDLE;
      end
    end
    if (key_done && st_reg.hardware_mode) begin
      st_next.hw_started = 1'b1;
      st_next.count      = '0;
    end

    // reset pulse generation
    if (timeout) begin
      st_next.pulse_cnt = 5'(PULSE_LEN);
      st_next.pulse_pin = !st_reg.reset_output_disable;
    end else if (st_reg.pulse_cnt != 5'h00) begin
      st_next.pulse_cnt = st_reg.pulse_cnt - WDC_PULSE_W_ONE;
      if (st_reg.pulse_cnt == WDC_PULSE_W_ONE) begin
        st_next.pulse_pin = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; power-on reset disables the watchdog
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      st_reg <= '{prescale: 3'h0, idle_freeze: 1'b0, reset_output_disable: 1'b0,
                  hardware_mode: 1'b0, software_restart: 1'b0, software_enable: 1'b0,
                  hw_started: 1'b0, key_state: WDC_KEY_IDLE, count: '0,
                  pulse_cnt: 5'h00, pulse_pin: 1'b0, rdata: WDC_CONTROL_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; pin drive only while pulse active and allowed
  assign O_RDATA      = st_reg.rdata;
  assign O_CORE_RST   = (st_reg.pulse_cnt != 5'h00);
  assign O_RST_PIN_O  = st_reg.pulse_pin;
  assign O_RST_PIN_OE = st_reg.pulse_pin;
  assign O_RUNNING    = running;
endmodule

// *** wdc_watchdog_checker.sv ***
// checker: port relations of the watchdog control unit
`timescale 1ns/1ps
module wdc_watchdog_checker
  import wdc_pkg::*;
#(
  parameter int PULSE_LEN = WDC_RESET_PULSE
) (
  input wire logic       I_MCLK,       // clock
  input wire logic       I_SYS_RST,    // reset
  input wire logic [7:0] I_ADDR,       // address
  input wire logic       I_WR,         // write strobe
  input wire logic [7:0] I_WDATA,      // write data
  input wire logic       I_RD,         // read strobe
  input wire logic [7:0] O_RDATA,      // read data
  input wire logic       O_CORE_RST,   // core reset
  input wire logic       O_RST_PIN_O,  // pin value
  input wire logic       O_RST_PIN_OE, // pin enable
  input wire logic       O_RUNNING     // running
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);
  // pulse checked at its default length of 16 cycles
  property p_pulse;
    $rose(O_CORE_RST) |-> O_CORE_RST [*8] ##1 O_CORE_RST [*8] ##1 !O_CORE_RST;
  endproperty
  a_pulse: assert property (p_pulse) else $error("core reset pulse length wrong");
  property p_cause; $rose(O_CORE_RST) |-> $past(O_RUNNING); endproperty
  a_cause: assert property (p_cause) else $error("reset while stopped");
  property p_oe; O_RST_PIN_OE == O_RST_PIN_O; endproperty
  a_oe: assert property (p_oe) else $error("pin enable differs from pin value");
  property p_pin; O_RST_PIN_O |-> O_CORE_RST; endproperty
  a_pin: assert property (p_pin) else $error("pin driven outside pulse");
  property p_rdz; !$past(I_RD) |-> O_RDATA == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside read cycle");
  property p_keyrd; I_RD && I_ADDR == WDC_ADDR_RESTART_KEY |=> O_RDATA == 8'h00; endproperty
  a_keyrd: assert property (p_keyrd) else $error("key register read not zero");
  // mode bit of the last control write; enable is write-ignored while it is set
  logic hw_sel_reg;
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      hw_sel_reg <= 1'b0;
    end else if (I_WR && I_ADDR == WDC_ADDR_CONTROL) begin
      hw_sel_reg <= I_WDATA[WDC_BIT_HW_MODE];
    end
  end
  property p_en;
    I_WR && I_ADDR == WDC_ADDR_CONTROL && I_WDATA == 8'h01 && !O_RUNNING && !hw_sel_reg
      |=> O_RUNNING;
  endproperty
  a_en: assert property (p_en) else $error("enable write did not start");
  property p_runrd; I_RD && I_ADDR == WDC_ADDR_CONTROL |=> O_RDATA[0] == $past(O_RUNNING); endproperty
  a_runrd: assert property (p_runrd) else $error("enable bit differs from running");
  c_tout: cover property ($rose(O_CORE_RST));
  c_pin: cover property (O_RST_PIN_O);
  c_run: cover property (O_RUNNING && I_WR);
endmodule
bind wdc_watchdog wdc_watchdog_checker #(.PULSE_LEN(PULSE_LEN)) chk_inst (
  .I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR), .I_WR(I_WR),
  .I_WDATA(I_WDATA), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_CORE_RST(O_CORE_RST),
  .O_RST_PIN_O(O_RST_PIN_O), .O_RST_PIN_OE(O_RST_PIN_OE), .O_RUNNING(O_RUNNING));

// *** watchdog_control_unit_tb_top.sv ***
// testbench: watchdog control unit scenarios
`timescale 1ns/1ps
module watchdog_control_unit_tb_top;
  import wdc_pkg::*;
  logic       I_MCLK = 0, I_SYS_RST = 1, I_WR = 0, I_RD = 0, I_IDLE = 0, I_POWER_DOWN = 0;
  logic [7:0] I_ADDR = 0, I_WDATA = 0, O_RDATA;
  logic       O_CORE_RST, O_RST_PIN_O, O_RST_PIN_OE, O_RUNNING;
  int         errors = 0, check_count = 0, n;
  wdc_watchdog wdc_watchdog_inst (.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_IDLE(I_IDLE),
    .I_POWER_DOWN(I_POWER_DOWN), .O_CORE_RST(O_CORE_RST), .O_RST_PIN_O(O_RST_PIN_O),
    .O_RST_PIN_OE(O_RST_PIN_OE), .O_RUNNING(O_RUNNING));
  initial begin
    forever #20 I_MCLK = ~I_MCLK;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge I_MCLK) {I_WR, I_ADDR, I_WDATA} <= {1'b1, a, d};
    @(posedge I_MCLK) I_WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge I_MCLK) {I_RD, I_ADDR} <= {1'b1, a};
    @(posedge I_MCLK) I_RD <= 1'b0;
    #1 chk("read data", O_RDATA, exp);
  endtask
  // bounded wait for the time-out pulse, cycles counted in n
  task automatic wait_tout();
    n = 0;
    while (O_CORE_RST !== 1'b1 && n < 40000) begin
      @(posedge I_MCLK) #1 n++;
    end
  endtask
  task automatic do_reset();
    @(posedge I_MCLK) I_SYS_RST <= 1'b1;
    repeat (8) @(posedge I_MCLK);
    I_SYS_RST <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(WDC_ADDR_CONTROL, WDC_CONTROL_RESET);
    rd(WDC_ADDR_RESTART_KEY, 8'h00);
    rd(8'h10, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_sw();
    wr(WDC_ADDR_CONTROL, 8'h01);
    chk("running", O_RUNNING, 1'b1);
    repeat (1000) @(posedge I_MCLK);
    wr(WDC_ADDR_CONTROL, 8'h00);
    chk("stopped", O_RUNNING, 1'b0);
    repeat (500) @(posedge I_MCLK);
    wr(WDC_ADDR_CONTROL, 8'h01);
    // count held at 1002 while stopped, so 15382 cycles remain
    wait_tout();
    chk("held count", n > 15370 && n < 15392, 1'b1);
    chk("pin", O_RST_PIN_O, 1'b1);
    chk("pin enable", O_RST_PIN_OE, 1'b1);
    repeat (500) @(posedge I_MCLK);
    wr(WDC_ADDR_CONTROL, 8'h03);
    rd(WDC_ADDR_CONTROL, 8'h01);
    I_POWER_DOWN <= 1'b1;
    repeat (500) @(posedge I_MCLK);
    I_POWER_DOWN <= 1'b0;
    wait_tout();
    chk("restart period", n > 16370 && n < 16392, 1'b1);
    do_reset();
    $display("test sw done");
  endtask
  task automatic t_idle();
    I_IDLE <= 1'b1;
    wr(WDC_ADDR_CONTROL, 8'h39);
    repeat (300) @(posedge I_MCLK);
    I_IDLE <= 1'b0;
    // prescale code 1: twice the shortest period
    wait_tout();
    chk("idle freeze", n > 32760 && n < 32780, 1'b1);
    chk("core", O_CORE_RST, 1'b1);
    chk("pin off", O_RST_PIN_O, 1'b0);
    chk("pin enable off", O_RST_PIN_OE, 1'b0);
    do_reset();
    $display("test idle done");
  endtask
  task automatic t_hw();
    wr(WDC_ADDR_CONTROL, 8'h04);
    chk("hw idle", O_RUNNING, 1'b0);
    wr(WDC_ADDR_RESTART_KEY, WDC_KEY_FIRST);
    wr(WDC_ADDR_RESTART_KEY, 8'h55);
    wr(WDC_ADDR_RESTART_KEY, WDC_KEY_SECOND);
    chk("broken key", O_RUNNING, 1'b0);
    wr(WDC_ADDR_RESTART_KEY, WDC_KEY_FIRST);
    wr(WDC_ADDR_RESTART_KEY, WDC_KEY_SECOND);
    chk("hw start", O_RUNNING, 1'b1);
    wr(WDC_ADDR_CONTROL, 8'h00);
    chk("hw stop refused", O_RUNNING, 1'b1);
    rd(WDC_ADDR_CONTROL, 8'h05);
    wr(WDC_ADDR_CONTROL, 8'h06);
    repeat (3) @(posedge I_MCLK);
    rd(WDC_ADDR_CONTROL, 8'h07);
    repeat (2000) @(posedge I_MCLK);
    wr(WDC_ADDR_RESTART_KEY, WDC_KEY_FIRST);
    wr(WDC_ADDR_RESTART_KEY, WDC_KEY_SECOND);
    wait_tout();
    chk("key restart period", n > 16370 && n < 16392, 1'b1);
    chk("hw pin", O_RST_PIN_O, 1'b1);
    do_reset();
    chk("reset stops", O_RUNNING, 1'b0);
    $display("test hw done");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(40 * 95000);
    errors++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge I_MCLK);
    I_SYS_RST <= 1'b0;
    t_regs();
    t_sw();
    t_idle();
    t_hw();
    conclude();
  end
endmodule
